/* inc/ssu_pkg.sv */
package ssu_pkg;
    localparam logic [7:0]  ADDR_STATUS  = 8'h00;
    localparam logic [7:0]  ADDR_ENABLE  = 8'h04;
    localparam logic [7:0]  ADDR_TXCFG   = 8'h08;
    localparam logic [7:0]  ADDR_CTRL    = 8'h0c;
    localparam logic [7:0]  ADDR_WMARK   = 8'h10;
    localparam int          B_RX_DATA_READY_FLAG1 = 15, B_RX_DATA_READY_FLAG0 = 14, B_TX_DATA_EMPTY_FLAG1 = 13, B_TX_DATA_EMPTY_FLAG0 = 12;
    localparam int          B_ROE1 = 11, B_ROE0 = 10, B_TX_UNDERRUN_FLAG1 = 9, B_TX_UNDERRUN_FLAG0 = 8;
    localparam int          B_TFS = 7, B_RFS = 6, B_TLS = 5, B_RLS = 4;
    localparam int          B_RX_FIFO_FULL_FLAG1 = 3, B_RX_FIFO_FULL_FLAG0 = 2, B_TX_FIFO_EMPTY_FLAG1 = 1, B_TX_FIFO_EMPTY_FLAG0 = 0;
    localparam int          B_RX_DMA_REQUEST_ENABLE = 22, B_RIE = 21, B_TX_DMA_REQUEST_ENABLE = 20, B_TIE = 19;
    localparam int          B_ALIGN = 9, B_TX_FIFO1_ENABLE = 8, B_TFEN0 = 7;
    localparam int          B_EN = 0, B_SRST = 1, B_TWOCH = 2, B_NET = 3, B_RFEN0 = 4, B_RFEN1 = 5;
    localparam logic [31:0] ENABLE_MASK  = 32'h007f_ffff;
    localparam logic [31:0] TXCFG_MASK   = 32'h0000_03ff;
    localparam logic [31:0] CTRL_MASK    = 32'h0000_003d;
    localparam logic [31:0] WMARK_MASK   = 32'h0000_ffff;
    localparam logic [31:0] WMARK_RESET  = 32'h0000_4444;
    localparam logic [18:0] RX_GROUP     = 19'h7_cc5c;
    localparam logic [18:0] TX_GROUP     = 19'h0_33a3;
    localparam logic [3:0]  WL_MSB31_MIN = 4'h7;
    localparam logic [4:0]  REF_BIT0     = 5'h00;
    localparam logic [4:0]  REF_BIT15    = 5'h0f;
    localparam logic [4:0]  REF_BIT31    = 5'h1f;

    // shifter events, one-cycle pulses on sys_clk
    typedef struct packed {
        logic word_start;
        logic tx_slot_start;
        logic tx_slot_first;
        logic tx_slot_last;
        logic tx_slot_masked;
        logic tx_fs_seen;
        logic rx_slot_start;
        logic rx_slot_last;
        logic rx_fs_seen;
    } ssu_evt_t;

    // fifo and holding register state
    typedef struct packed {
        logic [3:0] tx0_level;
        logic [3:0] tx1_level;
        logic [3:0] rx0_level;
        logic [3:0] rx1_level;
        logic       tx0_hold_empty;
        logic       tx1_hold_empty;
        logic       rx0_hold_full;
        logic       rx1_hold_full;
    } ssu_fifo_t;
endpackage : ssu_pkg

/* hw/ssu_status.sv */
`default_nettype none
module ssu_status
    import ssu_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bclk_pin,
    input  wire ssu_evt_t    evt,
    input  wire ssu_fifo_t   fifo,
    input  wire logic [3:0]  word_len,
    input  wire logic        tx_enable,
    output logic             irq,
    output logic             rx_dma_req,
    output logic             tx_dma_req,
    output logic [31:0]      tx_config,
    output logic [4:0]       shift_ref_bit,
    output logic             tx_repeat,
    output logic             rx1_discard,
    output logic             fifo_flush,
    output logic             module_en
);
    localparam logic [3:0] DEPTH = 4'(FIFO_DEPTH);

    logic [31:0] enable_q;
    logic [31:0] ctrl_q;
    logic [31:0] wmark_q;
    logic [18:0] stat_q;
    logic [4:0]  pend_q;
    logic        armed_q;
    logic [2:0]  bclk_q;
    logic        srst_q;
    logic        ready_q;
    logic        wr_done;
    logic        rd_done;
    logic        status_rd;
    logic        bclk_rise;
    logic        commit;
    logic        flag_clr;
    logic        two_ch;
    logic        net_mode;
    logic        tx_underrun_flag0_ev;
    logic        tx_underrun_flag1_ev;
    logic [4:0]  pend_in;
    logic [18:0] enabled_stat;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == ADDR_STATUS) || (a == ADDR_ENABLE) || (a == ADDR_TXCFG) ||
                   (a == ADDR_CTRL) || (a == ADDR_WMARK);
    endfunction

    function automatic logic [3:0] wm_field(input logic [31:0] w, input int idx);
        wm_field = w[idx*4 +: 4];
    endfunction

    // apb slave: one wait state, answer registered
    assign wr_done   = psel && penable && ready_q && pwrite;
    assign rd_done   = psel && penable && ready_q && !pwrite;
    assign status_rd = rd_done && (paddr == ADDR_STATUS);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ready_q <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            ready_q <= psel && penable && !ready_q;
            if (psel && penable && !ready_q) begin
                pslverr <= !addr_hit(paddr);
                case (paddr)
                    ADDR_STATUS: prdata <= {13'h0000, stat_q};
                    ADDR_ENABLE: prdata <= enable_q;
                    ADDR_TXCFG:  prdata <= tx_config;
                    ADDR_CTRL:   prdata <= ctrl_q;
                    ADDR_WMARK:  prdata <= wmark_q;
                    default:     prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign pready = ready_q;

    // control registers; tx configuration survives soft reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            enable_q  <= 32'h0000_0000;
            tx_config <= 32'h0000_0000;
            ctrl_q    <= 32'h0000_0000;
            wmark_q   <= WMARK_RESET;
        end else if (wr_done) begin
            case (paddr)
                ADDR_ENABLE: enable_q  <= pwdata & ENABLE_MASK;
                ADDR_TXCFG:  tx_config <= pwdata & TXCFG_MASK;
                ADDR_CTRL:   ctrl_q    <= pwdata & CTRL_MASK;
                ADDR_WMARK:  wmark_q   <= pwdata & WMARK_MASK;
                default:     ;
            endcase
        end
    end

    // soft reset is a self-clearing pulse, written as a one to ctrl bit 1
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            srst_q <= 1'b0;
        else
            srst_q <= wr_done && (paddr == ADDR_CTRL) && pwdata[B_SRST];
    end

    assign two_ch   = ctrl_q[B_TWOCH];
    assign net_mode = ctrl_q[B_NET];
    assign flag_clr = srst_q || !ctrl_q[B_EN];

    // bit clock from the pin, two stages then edge detect
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            bclk_q <= 3'b000;
        else
            bclk_q <= {bclk_q[1:0], bclk_pin};
    end
    assign bclk_rise = bclk_q[1] && !bclk_q[2];

    // word start arms; first bit clock edge afterwards commits pending events
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            armed_q <= 1'b0;
        else if (flag_clr)
            armed_q <= 1'b0;
        else if (evt.word_start)
            armed_q <= 1'b1;
        else if (bclk_rise)
            armed_q <= 1'b0;
    end
    assign commit = armed_q && bclk_rise && !evt.word_start;

    // underrun: an unmasked slot with nothing to send
    assign tx_underrun_flag0_ev = evt.tx_slot_start && !evt.tx_slot_masked && tx_enable &&
                     stat_q[B_TX_DATA_EMPTY_FLAG0];
    assign tx_underrun_flag1_ev = evt.tx_slot_start && !evt.tx_slot_masked && tx_enable &&
                     two_ch && stat_q[B_TX_DATA_EMPTY_FLAG1];
    // pend bits: 0 tx_underrun_flag0, 1 tx_underrun_flag1, 2 tfs, 3 tls, 4 rls
    assign pend_in = {evt.rx_slot_start && evt.rx_slot_last,
                      evt.tx_slot_start && evt.tx_slot_last,
                      evt.tx_fs_seen, tx_underrun_flag1_ev, tx_underrun_flag0_ev};

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            pend_q <= 5'h00;
        else if (flag_clr)
            pend_q <= 5'h00;
        else if (commit)
            pend_q <= pend_in;
        else
            pend_q <= pend_q | pend_in;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            tx_repeat <= 1'b0;
        else
            tx_repeat <= tx_underrun_flag0_ev || tx_underrun_flag1_ev;
    end

    // sticky event flags: set wins over the read clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stat_q[B_TX_UNDERRUN_FLAG0] <= 1'b0;
            stat_q[B_TX_UNDERRUN_FLAG1] <= 1'b0;
            stat_q[B_TLS]  <= 1'b0;
            stat_q[B_RLS]  <= 1'b0;
        end else if (flag_clr) begin
            stat_q[B_TX_UNDERRUN_FLAG0] <= 1'b0;
            stat_q[B_TX_UNDERRUN_FLAG1] <= 1'b0;
            stat_q[B_TLS]  <= 1'b0;
            stat_q[B_RLS]  <= 1'b0;
        end else begin
            stat_q[B_TX_UNDERRUN_FLAG0] <= (commit && pend_q[0]) || (stat_q[B_TX_UNDERRUN_FLAG0] && !status_rd);
            stat_q[B_TX_UNDERRUN_FLAG1] <= (commit && pend_q[1]) || (stat_q[B_TX_UNDERRUN_FLAG1] && !status_rd);
            stat_q[B_TLS]  <= (commit && pend_q[3]) || (stat_q[B_TLS] && !status_rd);
            stat_q[B_RLS]  <= (commit && pend_q[4]) || (stat_q[B_RLS] && !status_rd);
        end
    end

    // frame sync flags: held in normal mode, slot-tracked in network mode
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stat_q[B_TFS] <= 1'b0;
            stat_q[B_RFS] <= 1'b0;
        end else if (flag_clr) begin
            stat_q[B_TFS] <= 1'b0;
            stat_q[B_RFS] <= 1'b0;
        end else begin
            if (!net_mode)
                stat_q[B_TFS] <= 1'b1;
            else if (commit && pend_q[2])
                stat_q[B_TFS] <= 1'b1;
            else if (evt.tx_slot_start && !evt.tx_slot_first)
                stat_q[B_TFS] <= 1'b0;
            if (!net_mode)
                stat_q[B_RFS] <= 1'b1;
            else if (evt.rx_fs_seen)
                stat_q[B_RFS] <= 1'b1;
            else if (evt.rx_slot_start)
                stat_q[B_RFS] <= 1'b0;
        end
    end

    // level flags follow fifo state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stat_q[B_RX_DATA_READY_FLAG1] <= 1'b0;
            stat_q[B_RX_DATA_READY_FLAG0] <= 1'b0;
            stat_q[B_TX_DATA_EMPTY_FLAG1] <= 1'b1;
            stat_q[B_TX_DATA_EMPTY_FLAG0] <= 1'b1;
            stat_q[B_RX_FIFO_FULL_FLAG1] <= 1'b0;
            stat_q[B_RX_FIFO_FULL_FLAG0] <= 1'b0;
            stat_q[B_TX_FIFO_EMPTY_FLAG1] <= 1'b1;
            stat_q[B_TX_FIFO_EMPTY_FLAG0] <= 1'b1;
        end else if (flag_clr) begin
            stat_q[B_RX_DATA_READY_FLAG1] <= 1'b0;
            stat_q[B_RX_DATA_READY_FLAG0] <= 1'b0;
            stat_q[B_TX_DATA_EMPTY_FLAG1] <= 1'b1;
            stat_q[B_TX_DATA_EMPTY_FLAG0] <= 1'b1;
            stat_q[B_RX_FIFO_FULL_FLAG1] <= 1'b0;
            stat_q[B_RX_FIFO_FULL_FLAG0] <= 1'b0;
            stat_q[B_TX_FIFO_EMPTY_FLAG1] <= 1'b1;
            stat_q[B_TX_FIFO_EMPTY_FLAG0] <= 1'b1;
        end else begin
            stat_q[B_RX_DATA_READY_FLAG1] <= two_ch && (ctrl_q[B_RFEN1] ? (fifo.rx1_level != 4'h0) : fifo.rx1_hold_full);
            stat_q[B_RX_DATA_READY_FLAG0] <= ctrl_q[B_RFEN0] ? (fifo.rx0_level != 4'h0) : fifo.rx0_hold_full;
            stat_q[B_TX_DATA_EMPTY_FLAG1] <= tx_config[B_TX_FIFO1_ENABLE] ? (fifo.tx1_level < DEPTH)
                                                 : fifo.tx1_hold_empty;
            stat_q[B_TX_DATA_EMPTY_FLAG0] <= tx_config[B_TFEN0] ? (fifo.tx0_level < DEPTH) : fifo.tx0_hold_empty;
            stat_q[B_RX_FIFO_FULL_FLAG1] <= two_ch && ctrl_q[B_RFEN1] &&
                              (fifo.rx1_level >= wm_field(wmark_q, 1));
            stat_q[B_RX_FIFO_FULL_FLAG0] <= ctrl_q[B_RFEN0] && (fifo.rx0_level >= wm_field(wmark_q, 0));
            if (fifo.tx1_level < wm_field(wmark_q, 3))
                stat_q[B_TX_FIFO_EMPTY_FLAG1] <= 1'b1;
            else if (fifo.tx1_level > wm_field(wmark_q, 3))
                stat_q[B_TX_FIFO_EMPTY_FLAG1] <= 1'b0;
            if (fifo.tx0_level < wm_field(wmark_q, 2))
                stat_q[B_TX_FIFO_EMPTY_FLAG0] <= 1'b1;
            else if (fifo.tx0_level > wm_field(wmark_q, 2))
                stat_q[B_TX_FIFO_EMPTY_FLAG0] <= 1'b0;
        end
    end

    // overrun and command flags are held at zero here
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stat_q[B_ROE1] <= 1'b0;
            stat_q[B_ROE0] <= 1'b0;
            stat_q[18:16]  <= 3'b000;
        end else begin
            stat_q[B_ROE1] <= 1'b0;
            stat_q[B_ROE0] <= 1'b0;
            stat_q[18:16]  <= 3'b000;
        end
    end

    // interrupt: per-bit enable, then group master enable
    assign enabled_stat = stat_q & enable_q[18:0] &
                          ((enable_q[B_RIE] ? RX_GROUP : 19'h0_0000) |
                           (enable_q[B_TIE] ? TX_GROUP : 19'h0_0000));

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq        <= 1'b0;
            rx_dma_req <= 1'b0;
            tx_dma_req <= 1'b0;
        end else begin
            irq        <= |enabled_stat;
            rx_dma_req <= enable_q[B_RX_DMA_REQUEST_ENABLE] &&
                          ((ctrl_q[B_RFEN0] || ctrl_q[B_RFEN1]) ?
                           (stat_q[B_RX_FIFO_FULL_FLAG0] || stat_q[B_RX_FIFO_FULL_FLAG1]) :
                           (stat_q[B_RX_DATA_READY_FLAG0] || stat_q[B_RX_DATA_READY_FLAG1]));
            tx_dma_req <= enable_q[B_TX_DMA_REQUEST_ENABLE] &&
                          ((tx_config[B_TFEN0] || tx_config[B_TX_FIFO1_ENABLE]) ?
                           (stat_q[B_TX_FIFO_EMPTY_FLAG0] || stat_q[B_TX_FIFO_EMPTY_FLAG1]) :
                           (stat_q[B_TX_DATA_EMPTY_FLAG0] || stat_q[B_TX_DATA_EMPTY_FLAG1]));
        end
    end

    // shifter side outputs
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            shift_ref_bit <= REF_BIT0;
            rx1_discard   <= 1'b0;
            fifo_flush    <= 1'b1;
            module_en     <= 1'b0;
        end else begin
            if (tx_config[B_ALIGN])
                shift_ref_bit <= REF_BIT0;
            else if (word_len >= WL_MSB31_MIN)
                shift_ref_bit <= REF_BIT31;
            else
                shift_ref_bit <= REF_BIT15;
            rx1_discard <= two_ch && ctrl_q[B_RFEN1] && (fifo.rx1_level >= DEPTH);
            fifo_flush  <= !ctrl_q[B_EN];
            module_en   <= ctrl_q[B_EN];
        end
    end

    // assertions
    tls_read_clr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (status_rd && stat_q[B_TLS] && !(commit && pend_q[3]) && !flag_clr) |=> !stat_q[B_TLS])
        else $error("last-slot flag not cleared by status read");
    tls_commit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (commit && pend_q[3] && !flag_clr) |=> stat_q[B_TLS])
        else $error("last-slot flag missed");
    tx_underrun_flag0_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (commit && pend_q[0] && !flag_clr) |=> stat_q[B_TX_UNDERRUN_FLAG0])
        else $error("underrun flag 0 missed");
    event_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!stat_q[B_TX_UNDERRUN_FLAG0] && !commit && !flag_clr) |=> !stat_q[B_TX_UNDERRUN_FLAG0])
        else $error("underrun flag set without commit");
    tfs_normal_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!net_mode && !flag_clr) |=> stat_q[B_TFS])
        else $error("frame sync flag not held in normal mode");
    irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        irq == $past(|enabled_stat))
        else $error("interrupt does not follow enabled status");
    rx_master_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!enable_q[B_RIE] && !enable_q[B_TIE]) |=> !irq)
        else $error("interrupt without master enable");
    rx_dma_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !enable_q[B_RX_DMA_REQUEST_ENABLE] |=> !rx_dma_req)
        else $error("rx dma request while disabled");
    tx_dma_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enable_q[B_TX_DMA_REQUEST_ENABLE] && !(tx_config[B_TFEN0] || tx_config[B_TX_FIFO1_ENABLE]) && stat_q[B_TX_DATA_EMPTY_FLAG0])
        |=> tx_dma_req)
        else $error("tx dma request missing");
    rx_fifo_full_flag1_level_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (two_ch && ctrl_q[B_RFEN1] && !flag_clr && fifo.rx1_level >= wm_field(wmark_q, 1))
        |=> stat_q[B_RX_FIFO_FULL_FLAG1])
        else $error("rx fifo full flag 1 missed");
    cfg_soft_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (srst_q && !wr_done) |=> $stable(tx_config))
        else $error("soft reset changed tx configuration");
endmodule // ssu_status
`default_nettype wire

/* sim/ssu_codec_model.sv */
`default_nettype none
module ssu_codec_model
    import ssu_pkg::*;
(
    input  wire logic    sys_clk,
    output logic         bclk_pin,
    output var ssu_evt_t evt
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bclk_pin = 1'b0;
        evt      = '0;
    end

    // one word: slot events, word start, then a burst of bit clocks; bit clock idles low between words
    task automatic send(input logic last, input logic first, input logic fs);
        ssu_evt_t e;
        e = '0;
        e.tx_slot_start = 1'b1;
        e.rx_slot_start = 1'b1;
        e.tx_slot_last  = last;
        e.rx_slot_last  = last;
        e.tx_slot_first = first;
        e.tx_fs_seen    = fs;
        e.rx_fs_seen    = fs;
        @(posedge sys_clk);
        evt <= e;
        @(posedge sys_clk);
        evt <= '{word_start: 1'b1, default: 1'b0};
        @(posedge sys_clk);
        evt <= '0;
        // bit clock is free of the system clock phase
        #3;
        repeat (8) begin
            bclk_pin = ~bclk_pin;
            #16;
        end
    endtask
endmodule // ssu_codec_model
`default_nettype wire

/* sim/tb_top.sv */
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin errors++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_top
    import ssu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata, q, tx_config;
    logic        pready, pslverr, err, bclk_pin, irq, rx_dma_req, tx_dma_req;
    logic        tx_repeat, rx1_discard, fifo_flush, module_en;
    logic [4:0]  shift_ref_bit;
    logic [3:0]  word_len  = 4'h7;
    logic        tx_enable = 1'b1;
    ssu_evt_t    evt;
    ssu_fifo_t   fifo = '{4'h8, 4'h8, 4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0};
    ssu_fifo_t   fv;
    int          errors = 0;
    int          cmp_count = 0;
    int          rep_cnt   = 0;
    int          rep_base  = 0;

    always #2 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (tx_repeat === 1'b1) rep_cnt <= rep_cnt + 1;
    end

    ssu_codec_model codec (.sys_clk(sys_clk), .bclk_pin(bclk_pin), .evt(evt));

    ssu_status #(.FIFO_DEPTH(8)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bclk_pin(bclk_pin), .evt(evt), .fifo(fifo), .word_len(word_len), .tx_enable(tx_enable),
        .irq(irq), .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req), .tx_config(tx_config),
        .shift_ref_bit(shift_ref_bit), .tx_repeat(tx_repeat), .rx1_discard(rx1_discard),
        .fifo_flush(fifo_flush), .module_en(module_en)
    );

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one apb transfer; read data and error are taken at the edge that sees pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            errors++;
            print_verdict();
        end
    endtask

    task automatic lvl(input ssu_fifo_t f);
        @(posedge sys_clk);
        fifo <= f;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        apb(1'b0, ADDR_ENABLE, 32'h0); `CHK("enable_rst", 32'h0, q)
        apb(1'b0, ADDR_TXCFG, 32'h0); `CHK("txcfg_rst", 32'h0, q)
        apb(1'b0, 8'h20, 32'h0); `CHK("unmapped_err", 1'b1, err)
        apb(1'b1, ADDR_TXCFG, 32'hffff_ffff);
        apb(1'b1, ADDR_CTRL, 32'h0000_0002);
        apb(1'b0, ADDR_TXCFG, 32'h0); `CHK("txcfg_after_srst", TXCFG_MASK, q)
        repeat (3) @(posedge sys_clk);
        `CHK("ref_lsb", REF_BIT0, shift_ref_bit)
        apb(1'b1, ADDR_TXCFG, 32'h0000_0180);
        repeat (3) @(posedge sys_clk);
        `CHK("ref_msb31", REF_BIT31, shift_ref_bit)
        word_len <= 4'h3;
        repeat (3) @(posedge sys_clk);
        `CHK("ref_msb15", REF_BIT15, shift_ref_bit)
        // network mode: frame sync event sets frame sync, last slot sets both last-slot flags
        apb(1'b1, ADDR_CTRL, 32'h0000_0009);
        apb(1'b0, ADDR_STATUS, 32'h0);
        codec.send(1'b1, 1'b1, 1'b1);
        repeat (4) @(posedge sys_clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("tfs_net", 1'b1, q[B_TFS])
        `CHK("rfs_net", 1'b1, q[B_RFS])
        `CHK("tls_set", 1'b1, q[B_TLS])
        `CHK("rls_set", 1'b1, q[B_RLS])
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("tls_clr", 1'b0, q[B_TLS])
        `CHK("rls_clr", 1'b0, q[B_RLS])
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        repeat (3) @(posedge sys_clk);
        apb(1'b0, ADDR_STATUS, 32'h0); `CHK("tfs_normal", 1'b1, q[B_TFS])
        // underrun on channel 0 without two-channel mode
        fv = fifo;
        fv.tx0_level = 4'h0;
        fv.tx0_hold_empty = 1'b1;
        lvl(fv);
        rep_base = rep_cnt;
        codec.send(1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge sys_clk);
        apb(1'b0, ADDR_STATUS, 32'h0); `CHK("tx_underrun_flag0", 1'b1, q[B_TX_UNDERRUN_FLAG0])
        `CHK("repeat_word", 1, rep_cnt - rep_base)
        // transmitter off: an empty slot is no underrun
        tx_enable <= 1'b0;
        rep_base = rep_cnt;
        codec.send(1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge sys_clk);
        apb(1'b0, ADDR_STATUS, 32'h0); `CHK("tx_underrun_flag0_tx_off", 1'b0, q[B_TX_UNDERRUN_FLAG0])
        `CHK("repeat_tx_off", 0, rep_cnt - rep_base)
        tx_enable <= 1'b1;
        fv.tx0_level = 4'h8;
        fv.tx0_hold_empty = 1'b0;
        lvl(fv);
        // interrupt gating by master and per-bit enables
        apb(1'b1, ADDR_ENABLE, 32'h1 << B_TLS);
        codec.send(1'b1, 1'b0, 1'b0);
        repeat (4) @(posedge sys_clk);
        `CHK("irq_no_tie", 1'b0, irq)
        apb(1'b1, ADDR_ENABLE, (32'h1 << B_TLS) | (32'h1 << B_TIE));
        repeat (3) @(posedge sys_clk);
        `CHK("irq_tie", 1'b1, irq)
        apb(1'b0, ADDR_STATUS, 32'h0);
        repeat (3) @(posedge sys_clk);
        `CHK("irq_cleared", 1'b0, irq)
        apb(1'b1, ADDR_ENABLE, (32'h1 << B_RLS) | (32'h1 << B_RIE));
        codec.send(1'b1, 1'b0, 1'b0);
        repeat (4) @(posedge sys_clk);
        `CHK("irq_rie", 1'b1, irq)
        apb(1'b0, ADDR_STATUS, 32'h0);
        // fifo level flags and dma requests, two channels with fifos on
        apb(1'b1, ADDR_ENABLE, (32'h1 << B_TX_DMA_REQUEST_ENABLE) | (32'h1 << B_RX_DMA_REQUEST_ENABLE));
        apb(1'b1, ADDR_CTRL, 32'h0000_0035);
        fv.tx0_level = 4'h0;
        lvl(fv); `CHK("tx_fifo_empty_flag0_set", 1'b1, q[B_TX_FIFO_EMPTY_FLAG0])
        `CHK("tx_dma_on", 1'b1, tx_dma_req)
        fv.tx0_level = 4'h8;
        lvl(fv); `CHK("tx_fifo_empty_flag0_clr", 1'b0, q[B_TX_FIFO_EMPTY_FLAG0])
        `CHK("tx_dma_off", 1'b0, tx_dma_req)
        fv.tx1_level = 4'h3;
        lvl(fv); `CHK("tx_fifo_empty_flag1_set", 1'b1, q[B_TX_FIFO_EMPTY_FLAG1])
        fv.tx1_level = 4'h8;
        fv.rx0_level = 4'h8;
        lvl(fv); `CHK("tx_fifo_empty_flag1_clr", 1'b0, q[B_TX_FIFO_EMPTY_FLAG1])
        `CHK("rx_dma_on", 1'b1, rx_dma_req)
        fv.rx0_level = 4'h0;
        fv.rx1_level = 4'h8;
        lvl(fv); `CHK("rx_fifo_full_flag1_set", 1'b1, q[B_RX_FIFO_FULL_FLAG1])
        `CHK("rx1_discard", 1'b1, rx1_discard)
        fv.rx1_level = 4'h3;
        lvl(fv); `CHK("rx_fifo_full_flag1_clr", 1'b0, q[B_RX_FIFO_FULL_FLAG1])
        `CHK("rx_dma_off", 1'b0, rx_dma_req)
        // disabling flushes and restores status, config kept
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        repeat (3) @(posedge sys_clk);
        `CHK("flush", 1'b1, fifo_flush)
        `CHK("module_off", 1'b0, module_en)
        apb(1'b0, ADDR_TXCFG, 32'h0); `CHK("txcfg_kept", 32'h0000_0180, q)
        `CHK("txcfg_port", 32'h0000_0180, tx_config)
        // fifos off: tx dma follows the data empty flags, not the fifo empty flags
        apb(1'b1, ADDR_TXCFG, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        fv.tx0_level = 4'h0;
        lvl(fv); `CHK("tx_dma_hold_full", 1'b0, tx_dma_req)
        fv.tx0_hold_empty = 1'b1;
        lvl(fv); `CHK("tx_dma_hold_empty", 1'b1, tx_dma_req)
        `CHK("rx_dma_no_data", 1'b0, rx_dma_req)
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
